//--- verilog/psm_pkg.sv
// Constants, types and register map of the power-save mode control block.
// Assumes a 16-bit register port with one-cycle strobes and no wait states.
package psm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_DEEP_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_SEL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam int DSE_BIT = 0;
  localparam int OSC_NEW_LSB = 0;
  localparam int OSC_ACT_LSB = 4;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_WAKE_INT = 8;
  localparam int STAT_WAKE_WDT = 9;
  localparam int STAT_WAKE_RST = 10;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic OPERAND_SLEEP = 1'h0;
  localparam logic OPERAND_IDLE = 1'h1;
  localparam logic [2:0] OSC_RESET = 3'h0;
  localparam logic [2:0] OSC_LOW_POWER_RC = 3'h5;
  localparam int IRQ_COUNT = 8;

  typedef enum logic [1:0] {
    PSM_RUN = 2'b00,
    PSM_IDLE = 2'b01,
    PSM_SLEEP = 2'b10,
    PSM_DEEP = 2'b11
  } psm_mode_e;

  // Clock and power gates that leave the block.
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic sysclk_osc_en;
    logic io_freeze;
    logic sram_power;
    logic flash_power;
    logic fscm_en;
    logic low_power_rc_clock_en;
    logic calendar_en;
    logic deep_sleep_watchdog_en;
    logic async_periph_en;
  } psm_gates_s;

  // Whole state of the block.
  typedef struct packed {
    psm_mode_e mode;
    logic deep_sleep_enable;
    logic [2:0] new_oscillator_select;
    logic [2:0] active_osc;
    logic watchdog_clear;
    logic wake_int;
    logic wake_wdt;
    logic wake_rst;
    logic [15:0] rdata;
  } psm_state_s;

  localparam psm_state_s STATE_RESET = '{
    mode: PSM_RUN,
    deep_sleep_enable: 1'h0,
    new_oscillator_select: OSC_RESET,
    active_osc: OSC_RESET,
    watchdog_clear: 1'h0,
    wake_int: 1'h0,
    wake_wdt: 1'h0,
    wake_rst: 1'h0,
    rdata: 16'h0000
  };

endpackage : psm_pkg

//--- verilog/psm_power_save_mode_control.sv
// Power-save mode controller: Run, Idle, Sleep and Deep Sleep sequencing.
// Assumes all inputs are synchronous to clock and the core pulses the
// power-save instruction strobe for one cycle while it executes it.
//
// What this block does
// - Sleep stops clocks and halts code execution.
// - Idle halts processor; peripherals keep clocks.
// - Deep Sleep keeps only calendar and deep watchdog.
// - Deep Sleep freezes I/O, powers off memories.
// - Instruction operand selects Sleep or Idle.
// - Enabled interrupt, watchdog or reset wakes device.
// - Sleep shuts down system clock oscillator.
// - Sleep freezes I/O directions and levels.
// - Clock monitor inactive during Sleep.
// - Low-power RC runs if watchdog/calendar need it.
// - Watchdog cleared in the cycle Sleep is entered.
// - Sleep disables system-clocked peripherals only.
// - Wake-up resumes on same clock source.
// - Unlocked clock select write in Run switches oscillator.
`timescale 1ns/1ps

module psm_power_save_mode_control (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Processor core power-save instruction.
  input wire logic power_save_instruction,
  input wire logic power_save_operand,
  // Wake-up sources.
  input wire logic [psm_pkg::IRQ_COUNT-1:0] irq_request,
  input wire logic [psm_pkg::IRQ_COUNT-1:0] irq_enable,
  input wire logic watchdog_timeout,
  input wire logic device_reset_event,
  // Configuration levels.
  input wire logic watchdog_enable,
  input wire logic calendar_on_low_power_rc_clock,
  input wire logic clock_config_locked,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Clock tree, peripherals and memories.
  output psm_pkg::psm_gates_s gates,
  output logic [2:0] active_osc,
  output logic watchdog_clear,
  output logic cpu_halted
);

  // ****************************************************************
  // State
  // ****************************************************************
  psm_pkg::psm_state_s state;
  psm_pkg::psm_state_s next_state;
  logic int_wake;
  logic wake;
  logic wr_ctrl;
  logic wr_clk;
  logic wr_stat;

  // Wake request: any enabled interrupt, watchdog time-out or reset event.
  assign int_wake = |(irq_request & irq_enable);
  assign wake = int_wake | watchdog_timeout | device_reset_event;
  assign wr_ctrl = reg_write && (reg_addr == psm_pkg::ADDR_DEEP_CTRL);
  assign wr_clk = reg_write && (reg_addr == psm_pkg::ADDR_CLOCK_SEL);
  assign wr_stat = reg_write && (reg_addr == psm_pkg::ADDR_STATUS);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Sequences modes, holds the clock selection and serves register reads.
  always_comb
  begin
    next_state = state;
    next_state.watchdog_clear = 1'h0;
    next_state.rdata = 16'h0000;
    if (wr_ctrl)
    begin
      next_state.deep_sleep_enable = reg_wdata[psm_pkg::DSE_BIT];
    end
    if (wr_clk)
    begin
      next_state.new_oscillator_select = reg_wdata[psm_pkg::OSC_NEW_LSB +: 3];
    end
    // Switching is allowed only while running; low-power modes keep the source.
    if (wr_clk && !clock_config_locked && state.mode == psm_pkg::PSM_RUN)
    begin
      next_state.active_osc = reg_wdata[psm_pkg::OSC_NEW_LSB +: 3];
    end
    // Write one to clear the wake flags; a new cause below wins.
    if (wr_stat)
    begin
      if (reg_wdata[psm_pkg::STAT_WAKE_INT])
      begin
        next_state.wake_int = 1'h0;
      end
      if (reg_wdata[psm_pkg::STAT_WAKE_WDT])
      begin
        next_state.wake_wdt = 1'h0;
      end
      if (reg_wdata[psm_pkg::STAT_WAKE_RST])
      begin
        next_state.wake_rst = 1'h0;
      end
    end
    unique case (state.mode)
      psm_pkg::PSM_RUN:
      begin
        if (power_save_instruction)
        begin
          if (power_save_operand == psm_pkg::OPERAND_IDLE)
          begin
            next_state.mode = psm_pkg::PSM_IDLE;
          end
          else if (state.deep_sleep_enable)
          begin
            next_state.mode = psm_pkg::PSM_DEEP;
            next_state.watchdog_clear = watchdog_enable;
          end
          else
          begin
            next_state.mode = psm_pkg::PSM_SLEEP;
            next_state.watchdog_clear = watchdog_enable;
          end
        end
      end
      psm_pkg::PSM_IDLE, psm_pkg::PSM_SLEEP, psm_pkg::PSM_DEEP:
      begin
        if (wake)
        begin
          next_state.mode = psm_pkg::PSM_RUN;
          // Build on the cleared copy so a same-cycle clear of another cause still lands.
          next_state.wake_int = next_state.wake_int | int_wake;
          next_state.wake_wdt = next_state.wake_wdt | watchdog_timeout;
          next_state.wake_rst = next_state.wake_rst | device_reset_event;
          if (state.mode == psm_pkg::PSM_DEEP)
          begin
            next_state.deep_sleep_enable = 1'h0;
          end
        end
      end
    endcase
    // Read data stands only in the cycle after the read strobe.
    if (reg_read)
    begin
      unique case (reg_addr)
        psm_pkg::ADDR_DEEP_CTRL:
        begin
          next_state.rdata[psm_pkg::DSE_BIT] = state.deep_sleep_enable;
        end
        psm_pkg::ADDR_CLOCK_SEL:
        begin
          next_state.rdata[psm_pkg::OSC_NEW_LSB +: 3] = state.new_oscillator_select;
          next_state.rdata[psm_pkg::OSC_ACT_LSB +: 3] = state.active_osc;
        end
        psm_pkg::ADDR_STATUS:
        begin
          next_state.rdata[psm_pkg::STAT_MODE_LSB +: 2] = state.mode;
          next_state.rdata[psm_pkg::STAT_WAKE_INT] = state.wake_int;
          next_state.rdata[psm_pkg::STAT_WAKE_WDT] = state.wake_wdt;
          next_state.rdata[psm_pkg::STAT_WAKE_RST] = state.wake_rst;
        end
        default:
        begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
  end

  // Registers the whole state.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= psm_pkg::STATE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Gate decode
  // ****************************************************************
  // Turns the registered mode into clock, power and freeze controls.
  // The defaults describe Sleep without its I/O freeze: system clock, its monitor and clocked peripherals off,
  // while externally clocked and change-notification logic keeps running.
  always_comb
  begin
    gates.cpu_clk_en = 1'h0;
    gates.periph_clk_en = 1'h0;
    gates.sysclk_osc_en = 1'h0;
    gates.io_freeze = 1'h0;
    gates.sram_power = 1'h1;
    gates.flash_power = 1'h1;
    gates.fscm_en = 1'h0;
    gates.low_power_rc_clock_en = watchdog_enable | calendar_on_low_power_rc_clock;
    gates.calendar_en = 1'h1;
    gates.deep_sleep_watchdog_en = 1'h1;
    gates.async_periph_en = 1'h1;
    unique case (state.mode)
      psm_pkg::PSM_RUN:
      begin
        gates.cpu_clk_en = 1'h1;
        gates.periph_clk_en = 1'h1;
        gates.sysclk_osc_en = 1'h1;
        gates.fscm_en = 1'h1;
        gates.low_power_rc_clock_en = watchdog_enable | calendar_on_low_power_rc_clock |
          (state.active_osc == psm_pkg::OSC_LOW_POWER_RC);
      end
      psm_pkg::PSM_IDLE:
      begin
        gates.periph_clk_en = 1'h1;
        gates.sysclk_osc_en = 1'h1;
        gates.fscm_en = 1'h1;
      end
      psm_pkg::PSM_SLEEP:
      begin
        gates.io_freeze = 1'h1;
      end
      psm_pkg::PSM_DEEP:
      begin
        gates.io_freeze = 1'h1;
        gates.sram_power = 1'h0;
        gates.flash_power = 1'h0;
        gates.async_periph_en = 1'h0;
      end
    endcase
  end

  // Registered outputs to the core and clock switch.
  assign reg_rdata = state.rdata;
  assign active_osc = state.active_osc;
  assign watchdog_clear = state.watchdog_clear;
  assign cpu_halted = (state.mode != psm_pkg::PSM_RUN);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_sleep_entry_halts: assert property (
    (state.mode == psm_pkg::PSM_RUN && power_save_instruction &&
     power_save_operand == psm_pkg::OPERAND_SLEEP && !state.deep_sleep_enable)
    |=> (state.mode == psm_pkg::PSM_SLEEP && cpu_halted && !gates.cpu_clk_en))
    else $error("Sleep entry did not halt the processor.");

  a_idle_keeps_periph: assert property (
    (state.mode == psm_pkg::PSM_RUN && power_save_instruction &&
     power_save_operand == psm_pkg::OPERAND_IDLE)
    |=> (gates.periph_clk_en && !gates.cpu_clk_en))
    else $error("Idle entry gated peripherals or left the processor clocked.");

  a_deep_only_keepers: assert property (
    (state.mode == psm_pkg::PSM_DEEP)
    |-> (gates.calendar_en && gates.deep_sleep_watchdog_en && !gates.periph_clk_en &&
         !gates.async_periph_en && !gates.sysclk_osc_en))
    else $error("Deep Sleep left a wrong unit running.");

  a_deep_entry_power: assert property (
    (state.mode == psm_pkg::PSM_RUN && power_save_instruction &&
     power_save_operand == psm_pkg::OPERAND_SLEEP && state.deep_sleep_enable)
    |=> (gates.io_freeze && !gates.sram_power && !gates.flash_power))
    else $error("Deep Sleep entry did not freeze I/O or remove memory power.");

  a_wake_low_power: assert property (
    (state.mode != psm_pkg::PSM_RUN && wake)
    |=> (state.mode == psm_pkg::PSM_RUN && gates.cpu_clk_en))
    else $error("Wake event did not return to Run.");

  a_sleep_osc_off: assert property (
    (state.mode == psm_pkg::PSM_SLEEP) |-> (!gates.sysclk_osc_en && !gates.fscm_en))
    else $error("Oscillator or clock monitor active in Sleep.");

  a_sleep_io_hold: assert property (
    (state.mode == psm_pkg::PSM_SLEEP && !wake) |=> gates.io_freeze)
    else $error("I/O released while Sleep continued.");

  a_sleep_low_power_rc_clock_need: assert property (
    (state.mode == psm_pkg::PSM_SLEEP && (watchdog_enable || calendar_on_low_power_rc_clock))
    |-> gates.low_power_rc_clock_en)
    else $error("Low-power RC stopped while needed in Sleep.");

  a_watchdog_clear_pulse: assert property (
    (state.mode == psm_pkg::PSM_RUN && power_save_instruction &&
     power_save_operand == psm_pkg::OPERAND_SLEEP && watchdog_enable)
    |=> watchdog_clear ##1 !watchdog_clear)
    else $error("Watchdog not cleared once on Sleep entry.");

  a_osc_kept_asleep: assert property (
    (state.mode != psm_pkg::PSM_RUN) |=> $stable(active_osc))
    else $error("Clock source changed during a low-power mode.");

  a_unlocked_switch: assert property (
    (wr_clk && !clock_config_locked && state.mode == psm_pkg::PSM_RUN)
    |=> (active_osc == $past(reg_wdata[2:0])))
    else $error("Unlocked clock select write did not switch.");

  // Gate levels held throughout each low-power mode; Deep Sleep entry clear and wake-up enable drop.
  a_sleep_periph_gated: assert property (
    (state.mode == psm_pkg::PSM_SLEEP)
    |-> (!gates.periph_clk_en && !gates.cpu_clk_en && gates.async_periph_en))
    else $error("Sleep left a clocked peripheral running or stopped an external one.");

  a_monitor_off_low: assert property (
    (state.mode == psm_pkg::PSM_SLEEP || state.mode == psm_pkg::PSM_DEEP) |-> !gates.fscm_en)
    else $error("Clock monitor active while the system clock was off.");

  a_idle_no_freeze: assert property (
    (state.mode == psm_pkg::PSM_IDLE)
    |-> (!gates.io_freeze && gates.sysclk_osc_en && cpu_halted))
    else $error("Idle froze I/O or stopped the system clock.");

  a_low_power_rc_clock_off_unneeded: assert property (
    (state.mode == psm_pkg::PSM_SLEEP && !watchdog_enable && !calendar_on_low_power_rc_clock)
    |-> !gates.low_power_rc_clock_en)
    else $error("Low-power RC left running in Sleep with no user.");

  a_deep_watchdog_clear: assert property (
    (state.mode == psm_pkg::PSM_RUN && power_save_instruction && state.deep_sleep_enable &&
     power_save_operand == psm_pkg::OPERAND_SLEEP) |=> (watchdog_clear == $past(watchdog_enable)))
    else $error("Watchdog clear on Deep Sleep entry did not follow its enable.");

  a_deep_enable_drop: assert property (
    (state.mode == psm_pkg::PSM_DEEP && wake) |=> !state.deep_sleep_enable)
    else $error("Deep Sleep enable survived the wake-up.");

  // Wake flags: a new cause wins over a clear in the same cycle, other clears land.
  a_wake_flag_wins: assert property (
    (state.mode != psm_pkg::PSM_RUN && int_wake && wr_stat &&
     reg_wdata[psm_pkg::STAT_WAKE_INT])
    |=> state.wake_int)
    else $error("Status clear hid a wake cause that arrived with it.");

  a_flag_clear_lands: assert property (
    (wr_stat && reg_wdata[psm_pkg::STAT_WAKE_WDT] && !watchdog_timeout) |=> !state.wake_wdt)
    else $error("Write-one-to-clear of the watchdog wake flag was lost.");

  // Main scenarios that the bench should reach.
  c_sleep_wake: cover property (
    state.mode == psm_pkg::PSM_SLEEP ##1 state.mode == psm_pkg::PSM_RUN);
  c_idle_wake: cover property (
    state.mode == psm_pkg::PSM_IDLE ##1 state.mode == psm_pkg::PSM_RUN);
  c_deep_wake: cover property (
    state.mode == psm_pkg::PSM_DEEP ##1 state.mode == psm_pkg::PSM_RUN);
  c_flag_race: cover property (
    state.mode != psm_pkg::PSM_RUN && wake && wr_stat);
  c_locked_write: cover property (
    wr_clk && clock_config_locked);

endmodule : psm_power_save_mode_control

//--- verif/psm_core_model.sv
// Behavioural processor core that executes the power-save instruction.
// Assumes the bench asks for one instruction at a time.
`timescale 1ns/1ps

module psm_core_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Bench request.
  input wire logic exec_req,
  input wire logic exec_op,
  // Core side of the block.
  input wire logic cpu_halted,
  output logic power_save_instruction,
  output logic power_save_operand
);
  // ********
  // Issue
  // ********
  // A halted core executes nothing, so a request made then is dropped.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      power_save_instruction <= 1'h0;
      power_save_operand <= 1'h0;
    end
    else if (exec_req && !cpu_halted)
    begin
      power_save_instruction <= 1'h1;
      power_save_operand <= exec_op;
    end
    else
    begin
      // The operand means nothing between strobes, so it keeps toggling.
      power_save_instruction <= 1'h0;
      power_save_operand <= ~power_save_operand;
    end
  end
endmodule : psm_core_model

//--- verif/psm_power_save_mode_control_tb_top.sv
// Self-checking bench of the power-save mode controller.
// Assumes the core model issues the instruction one cycle after a request.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module psm_power_save_mode_control_tb_top;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic exec_req = 1'h0;
  logic exec_op = 1'h0;
  logic [7:0] irq_request = 8'h00;
  logic [7:0] irq_enable = 8'hFF;
  logic watchdog_timeout = 1'h0;
  logic device_reset_event = 1'h0;
  logic watchdog_enable = 1'h0;
  logic calendar_on_low_power_rc_clock = 1'h0;
  logic clock_config_locked = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic [15:0] reg_rdata;
  psm_pkg::psm_gates_s gates;
  logic [2:0] active_osc;
  logic watchdog_clear;
  logic cpu_halted;
  logic psi;
  logic pso;
  logic [7:0] gv;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  // ********
  // Harness
  // ********
  // The 20 MHz clock.
  always #25 clock = ~clock;
  assign gv = {gates.cpu_clk_en, gates.periph_clk_en, gates.sysclk_osc_en, gates.io_freeze,
    gates.sram_power, gates.flash_power, gates.fscm_en, gates.async_periph_en};

  psm_power_save_mode_control i_dut (.clock(clock), .resetn(resetn),
    .power_save_instruction(psi), .power_save_operand(pso), .irq_request(irq_request),
    .irq_enable(irq_enable), .watchdog_timeout(watchdog_timeout),
    .device_reset_event(device_reset_event), .watchdog_enable(watchdog_enable),
    .calendar_on_low_power_rc_clock(calendar_on_low_power_rc_clock), .clock_config_locked(clock_config_locked),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .gates(gates), .active_osc(active_osc),
    .watchdog_clear(watchdog_clear), .cpu_halted(cpu_halted));

  psm_core_model i_core (.clock(clock), .resetn(resetn), .exec_req(exec_req),
    .exec_op(exec_op), .cpu_halted(cpu_halted), .power_save_instruction(psi),
    .power_save_operand(pso));

  // ********
  // Tasks
  // ********
  // Expected gates {cpu, periph, sysclk, freeze, sram, flash, monitor, async}.
  function automatic logic [7:0] gexp(input psm_pkg::psm_mode_e m);
    case (m)
      psm_pkg::PSM_RUN: return 8'hEF;
      psm_pkg::PSM_IDLE: return 8'h6F;
      psm_pkg::PSM_SLEEP: return 8'h1D;
      default: return 8'h10;
    endcase
  endfunction : gexp

  task automatic chk_mode(input psm_pkg::psm_mode_e m);
    `CHK("gates", gexp(m), gv)
    `CHK("cpu_halted", m != psm_pkg::PSM_RUN, cpu_halted)
  endtask : chk_mode

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask : wr

  // The read data stand only in the cycle after the read strobe.
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clock);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'h0;
    @(negedge clock);
    `CHK(nm, e, reg_rdata)
  endtask : rd

  task automatic save(input logic op, input psm_pkg::psm_mode_e m);
    @(posedge clock);
    exec_req <= 1'h1;
    exec_op <= op;
    @(posedge clock);
    exec_req <= 1'h0;
    @(posedge clock);
    @(negedge clock);
    chk_mode(m);
    `CHK("watchdog_clear", watchdog_enable && m[1], watchdog_clear)
    @(negedge clock);
    `CHK("watchdog_clear", 1'h0, watchdog_clear)
  endtask : save

  // Source bits: 0 interrupt, 1 watchdog, 2 reset event; a status clear rides along,
  // so the new cause must win over it.
  task automatic wake(input logic [2:0] src, input logic [15:0] st);
    @(posedge clock);
    irq_request <= src[0] ? 8'h20 : 8'h00;
    watchdog_timeout <= src[1];
    device_reset_event <= src[2];
    reg_write <= 1'h1;
    reg_addr <= psm_pkg::ADDR_STATUS;
    reg_wdata <= 16'h0700;
    @(posedge clock);
    irq_request <= 8'h00;
    watchdog_timeout <= 1'h0;
    device_reset_event <= 1'h0;
    reg_write <= 1'h0;
    @(negedge clock);
    chk_mode(psm_pkg::PSM_RUN);
    rd(psm_pkg::ADDR_STATUS, st, "status");
    wr(psm_pkg::ADDR_STATUS, 16'h0700);
    rd(psm_pkg::ADDR_STATUS, 16'h0000, "status_clear");
  endtask : wake

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // ********
  // Tests
  // ********
  // A hang is cut short well beyond the expected run.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      end_sim();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clock);
    resetn <= 1'h1;
    @(negedge clock);
    chk_mode(psm_pkg::PSM_RUN);
    `CHK("low_power_rc_clock_en", 1'h0, gates.low_power_rc_clock_en)
    rd(psm_pkg::ADDR_CLOCK_SEL, 16'h0000, "clock_sel");
    rd(4'hF, 16'h0000, "unmapped");
    $display("test reset done");
    save(psm_pkg::OPERAND_IDLE, psm_pkg::PSM_IDLE);
    rd(psm_pkg::ADDR_STATUS, 16'h0001, "status");
    @(posedge clock);
    irq_enable <= 8'hDF;
    irq_request <= 8'h20;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk_mode(psm_pkg::PSM_IDLE);
    @(posedge clock);
    irq_request <= 8'h00;
    irq_enable <= 8'hFF;
    wake(3'h1, 16'h0100);
    $display("test idle done");
    @(posedge clock);
    watchdog_enable <= 1'h1;
    save(psm_pkg::OPERAND_SLEEP, psm_pkg::PSM_SLEEP);
    `CHK("low_power_rc_clock_en", 1'h1, gates.low_power_rc_clock_en)
    rd(psm_pkg::ADDR_STATUS, 16'h0002, "status");
    wake(3'h2, 16'h0200);
    $display("test sleep done");
    @(posedge clock);
    watchdog_enable <= 1'h0;
    calendar_on_low_power_rc_clock <= 1'h1;
    wr(psm_pkg::ADDR_DEEP_CTRL, 16'h0001);
    save(psm_pkg::OPERAND_SLEEP, psm_pkg::PSM_DEEP);
    `CHK("keep", 3'h7, {gates.calendar_en, gates.deep_sleep_watchdog_en, gates.low_power_rc_clock_en})
    wake(3'h4, 16'h0400);
    rd(psm_pkg::ADDR_DEEP_CTRL, 16'h0000, "deep_ctrl");
    $display("test deep done");
    @(posedge clock);
    calendar_on_low_power_rc_clock <= 1'h0;
    wr(psm_pkg::ADDR_CLOCK_SEL, {13'h0000, psm_pkg::OSC_LOW_POWER_RC});
    @(negedge clock);
    `CHK("active_osc", psm_pkg::OSC_LOW_POWER_RC, active_osc)
    rd(psm_pkg::ADDR_CLOCK_SEL, 16'h0055, "clock_sel");
    save(psm_pkg::OPERAND_SLEEP, psm_pkg::PSM_SLEEP);
    wake(3'h1, 16'h0100);
    `CHK("active_osc", psm_pkg::OSC_LOW_POWER_RC, active_osc)
    @(posedge clock);
    clock_config_locked <= 1'h1;
    wr(psm_pkg::ADDR_CLOCK_SEL, 16'h0000);
    rd(psm_pkg::ADDR_CLOCK_SEL, 16'h0050, "clock_sel");
    $display("test clock done");
    // A resetn pulse in Idle returns to Run and restores the reset clock source.
    save(psm_pkg::OPERAND_IDLE, psm_pkg::PSM_IDLE);
    @(posedge clock);
    resetn <= 1'h0;
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    @(negedge clock);
    chk_mode(psm_pkg::PSM_RUN);
    `CHK("active_osc", psm_pkg::OSC_RESET, active_osc)
    $display("test reset wake done");
    end_sim();
  end
endmodule : psm_power_save_mode_control_tb_top
